// ### rcp_stage.sv
// Purpose: One residual current protection stage with APB settings
// Assumes: Measurements and block come from logic on the same clock
// Notes: Evaluation runs once per processing cycle tick
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
// How it works
// - Supervisory threshold writes accepted only when control code says allowed.
// - Output status forcing 0..3 honoured only while test enable is set.
// - Magnitude RMS, TRMS or peak-to-peak, only for measured inputs.
// - Source code picks coarse, sensitive or calculated residual current.
// - Pick-up sets when measured magnitude exceeds the threshold.
// - Pick-up releases only below 97 percent of the threshold.
// - One threshold, 0.0001 nominal steps, default 1.20, for every channel.
// - START only from pick-up with no blocking, then trip timing.
// - Blocking sampled once at each processing cycle before evaluation.
// - Blocking at pick-up gives BLOCKED instead of START, no further processing.
// - Blocking during START clears it and runs normal release timing.
// - Optional second harmonic blocking above a limit in 0.01 percent steps.
// - Blocking emits stamped event with currents and fault type, plus display pulse.
// - Trip timing by definite time or inverse characteristic.
// - Readable stage condition 0 normal, 1 start, 2 trip, 3 blocked.
// - Fault type and direction of the last fault reported as 0..6.
// - Remaining time to trip exposed, 5 ms steps, up to 1800 s.
// - Expected operating time recomputed each cycle under the inverse curve.
// - Ratio of measured current to threshold exposed in 0.01 steps.
// - Residual angle against voltage reference when present, else current reference.
// - Software blocking switch usable only while test enable is set.
// - ON and OFF changes stamped in 1 ms; instant mode stamps match.
// - Twelve latest ON records kept with stamp and process data.
module rcp_stage #(
  parameter int CYCLE_CLKS = rcp_pkg::CYCLE_CLKS,
  parameter int STAMP_CLKS = rcp_pkg::STAMP_CLKS
) (
  // Clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RESET_N,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic O_PREADY,
  output logic [31:0] O_PRDATA,
  output logic O_PSLVERR,
  // Measured magnitudes, 0.0001 x In
  input wire logic [rcp_pkg::MW-1:0] I_COARSE_RMS,
  input wire logic [rcp_pkg::MW-1:0] I_COARSE_TRMS,
  input wire logic [rcp_pkg::MW-1:0] I_COARSE_PP,
  input wire logic [rcp_pkg::MW-1:0] I_SENS_RMS,
  input wire logic [rcp_pkg::MW-1:0] I_SENS_TRMS,
  input wire logic [rcp_pkg::MW-1:0] I_SENS_PP,
  input wire logic [rcp_pkg::MW-1:0] I_CALC,
  // Harmonic ratio, blocking and fault data
  input wire logic [15:0] I_HARM2_RATIO,
  input wire logic I_BLOCK,
  input wire logic [2:0] I_FAULT_TYPE,
  input wire logic [15:0] I_RES_ANGLE,
  input wire logic [15:0] I_VREF_ANGLE,
  input wire logic [15:0] I_IREF_ANGLE,
  input wire logic I_VOLT_OK,
  // Supervisory threshold write
  input wire logic I_COMM_WR,
  input wire logic [rcp_pkg::MW-1:0] I_COMM_THRESH,
  // Stage outputs and events
  output logic O_START,
  output logic O_TRIP,
  output logic O_BLOCKED,
  output logic [5:0] O_EVT,
  output logic [31:0] O_EVT_STAMP,
  output logic O_HMI_EVT
);
  import rcp_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [MW-1:0] thr;
    logic [15:0] hlim;
    logic [TW-1:0] dly;
    logic [TW-1:0] rdly;
    logic [19:0] cyc;
    logic [17:0] msdiv;
    logic [31:0] stamp;
    logic tick;
    logic blk_s;
    logic pick;
    rcp_cond_t cond;
    rcp_cond_t stat;
    logic [TW-1:0] elapsed;
    logic [TW-1:0] rcnt;
    logic [TW-1:0] texp;
    logic [TW-1:0] trem;
    logic [RW-1:0] ratio;
    logic [AW-1:0] angle;
    logic [2:0] ftype;
    logic [REC_IW-1:0] rsel;
    logic [REC_IW-1:0] wptr;
    rcp_rec_t [REC_N-1:0] rec;
    logic start;
    logic trip;
    logic blocked;
    logic [5:0] evt;
    logic [31:0] evt_stamp;
    logic hmi;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } rcp_st_t;

  rcp_st_t s;
  rcp_st_t n;
  logic [1:0] src;
  logic [1:0] mag;
  logic [MW-1:0] meas;
  logic [MW-1:0] coarse;
  logic [MW-1:0] sens;
  logic blk;
  logic above_rel;
  logic apb_wr;

  // Source and magnitude selection
  assign src = s.ctrl[F_SRC +: 2];
  assign mag = s.ctrl[F_MAG +: 2];
  assign coarse = (mag == MAG_TRMS) ? I_COARSE_TRMS :
                  (mag == MAG_PP) ? I_COARSE_PP : I_COARSE_RMS;
  assign sens = (mag == MAG_TRMS) ? I_SENS_TRMS :
                (mag == MAG_PP) ? I_SENS_PP : I_SENS_RMS;
  assign meas = (src == SRC_CALC) ? I_CALC :
                (src == SRC_SENS) ? sens : coarse;

  // Combined blocking: input, inrush, software switch
  assign blk = I_BLOCK
    | (s.ctrl[F_HARM] & (I_HARM2_RATIO > s.hlim))
    | (s.ctrl[F_TEST] & s.ctrl[F_SOFTBLK]);
  // Still above the 97 percent release level
  assign above_rel = ({7'h00, meas} * 27'(PCT))
    >= ({7'h00, s.thr} * 27'(HYST_PCT));
  assign apb_wr = I_PSEL & I_PENABLE & I_PWRITE & s.pready;

  // Next state of the whole stage
  always_comb begin
    logic pick;
    logic [26:0] q;
    logic [RW-1:0] ratio;
    logic [RW-1:0] rint;
    logic [2:0] lg;
    logic [TW-1:0] texp;
    logic [31:0] rd;
    logic hit;
    rcp_cond_t fc;
    logic [5:0] ev;
    pick = s.pick;
    q = '0;
    ratio = '0;
    rint = '0;
    lg = '0;
    texp = '0;
    rd = '0;
    hit = 1'b1;
    fc = C_NORMAL;
    ev = '0;
    n = s;
    n.tick = 1'b0;
    n.hmi = 1'b0;
    n.evt = '0;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    // Processing cycle divider
    if (s.cyc == 20'(CYCLE_CLKS - 1)) begin
      n.cyc = '0;
      n.tick = 1'b1;
    end else begin
      n.cyc = s.cyc + 20'h00001;
    end
    // 1 ms time stamp
    if (s.msdiv == 18'(STAMP_CLKS - 1)) begin
      n.msdiv = '0;
      n.stamp = s.stamp + 32'h00000001;
    end else begin
      n.msdiv = s.msdiv + 18'h00001;
    end
    // Hysteresis comparator on the common threshold
    if (meas > s.thr) begin
      pick = 1'b1;
    end else if (!above_rel) begin
      pick = 1'b0;
    end
    // Ratio to threshold, 0.01 steps
    if (s.thr != '0) begin
      q = ({7'h00, meas} * 27'(PCT)) / {7'h00, s.thr};
    end
    ratio = (q > 27'(RATIO_MAX)) ? RATIO_MAX : q[RW-1:0];
    rint = ratio / 17'h00064;
    // Coarse inverse curve: delay halves per doubling
    for (int i = 1; i < 7; i++) begin
      if (rint >= (17'h00001 << i)) begin
        lg = 3'(i);
      end
    end
    texp = s.ctrl[F_IDMT] ? (s.dly >> lg) : s.dly;
    // Once per processing cycle
    if (s.tick) begin
      n.blk_s = blk;
      n.pick = pick;
      n.texp = texp;
      n.ratio = ratio;
      n.angle = AW'({1'b0, I_RES_ANGLE})
        - AW'({1'b0, I_VOLT_OK ? I_VREF_ANGLE : I_IREF_ANGLE});
      case (s.cond)
        C_NORMAL: begin
          if (pick && blk) begin
            n.cond = C_BLOCKED;
            n.ftype = I_FAULT_TYPE;
          end else if (pick) begin
            n.ftype = I_FAULT_TYPE;
            n.rcnt = '0;
            if (s.elapsed + 19'h00001 >= texp) begin
              n.cond = C_TRIP;
            end else begin
              n.cond = C_START;
              n.elapsed = s.elapsed + 19'h00001;
            end
          end else if (s.elapsed != '0) begin
            // Release timing before the count is lost
            if (s.rcnt + 19'h00001 >= s.rdly) begin
              n.elapsed = '0;
              n.rcnt = '0;
            end else begin
              n.rcnt = s.rcnt + 19'h00001;
            end
          end
        end
        C_START: begin
          if (blk || !pick) begin
            n.cond = C_NORMAL;
            n.rcnt = '0;
          end else if (s.elapsed + 19'h00001 >= texp) begin
            n.cond = C_TRIP;
          end else begin
            n.elapsed = s.elapsed + 19'h00001;
          end
        end
        C_TRIP: begin
          if (blk || !pick) begin
            n.cond = C_NORMAL;
            n.elapsed = '0;
            n.rcnt = '0;
          end
        end
        default: begin
          if (!blk || !pick) begin
            n.cond = C_NORMAL;
          end
        end
      endcase
      n.trem = (n.cond == C_START && texp > n.elapsed) ?
        texp - n.elapsed : '0;
    end
    // Forced or real condition drives the outputs
    if (s.ctrl[F_TEST] && s.ctrl[F_FORCE +: 2] != 2'h0) begin
      fc = rcp_cond_t'(s.ctrl[F_FORCE +: 2]);
    end else begin
      fc = n.cond;
    end
    n.stat = fc;
    n.start = (fc == C_START) || (fc == C_TRIP);
    n.trip = (fc == C_TRIP);
    n.blocked = (fc == C_BLOCKED);
    // Edge events, all sharing one stamp
    ev = {n.start & ~s.start, ~n.start & s.start,
          n.trip & ~s.trip, ~n.trip & s.trip,
          n.blocked & ~s.blocked, ~n.blocked & s.blocked};
    n.evt = ev;
    if (ev != 6'h00) begin
      n.evt_stamp = s.stamp;
    end
    n.hmi = ev[1];
    // Keep the latest ON records in a ring
    if (ev[5] || ev[3] || ev[1]) begin
      n.rec[s.wptr].stamp = s.stamp;
      n.rec[s.wptr].ev = ev[3] ? 2'h2 : ev[5] ? 2'h1 : 2'h3;
      n.rec[s.wptr].ftype = n.ftype;
      n.rec[s.wptr].cur = meas;
      n.wptr = (s.wptr == 4'(REC_N - 1)) ? '0 : s.wptr + 4'h1;
    end
    // Supervisory threshold change
    if (I_COMM_WR && s.ctrl[F_COMM +: 2] == COMM_ALLOW) begin
      n.thr = I_COMM_THRESH;
    end
    // APB read decode in the setup cycle
    if (A_CTRL == I_PADDR) begin
      rd = {20'h00000, s.ctrl};
    end else if (A_THRESH == I_PADDR) begin
      rd = {12'h000, s.thr};
    end else if (A_HLIM == I_PADDR) begin
      rd = {16'h0000, s.hlim};
    end else if (A_DLY == I_PADDR) begin
      rd = {13'h0000, s.dly};
    end else if (A_RDLY == I_PADDR) begin
      rd = {13'h0000, s.rdly};
    end else if (A_STATUS == I_PADDR) begin
      rd = {25'h0000000, s.blk_s, s.pick, s.ftype, s.stat};
    end else if (A_TREM == I_PADDR) begin
      rd = {13'h0000, s.trem};
    end else if (A_TEXP == I_PADDR) begin
      rd = {13'h0000, s.texp};
    end else if (A_RATIO == I_PADDR) begin
      rd = {15'h0000, s.ratio};
    end else if (A_ANGLE == I_PADDR) begin
      rd = {{15{s.angle[AW-1]}}, s.angle};
    end else if (A_RSEL == I_PADDR) begin
      rd = {28'h0000000, s.rsel};
    end else if (A_RSTAMP == I_PADDR) begin
      rd = s.rec[s.rsel].stamp;
    end else if (A_RINFO == I_PADDR) begin
      rd = {7'h00, s.rec[s.rsel].ev, s.rec[s.rsel].ftype, s.rec[s.rsel].cur};
    end else begin
      hit = 1'b0;
    end
    if (I_PSEL && !I_PENABLE) begin
      n.pready = 1'b1;
      n.pslverr = !hit;
      n.prdata = I_PWRITE ? 32'h00000000 : rd;
    end
    // APB writes take effect at the access edge
    if (apb_wr) begin
      if (A_CTRL == I_PADDR) begin
        n.ctrl = I_PWDATA[CTRL_W-1:0];
      end else if (A_THRESH == I_PADDR) begin
        n.thr = I_PWDATA[MW-1:0];
      end else if (A_HLIM == I_PADDR) begin
        n.hlim = I_PWDATA[15:0];
      end else if (A_DLY == I_PADDR) begin
        n.dly = (I_PWDATA > 32'(TREM_MAX)) ? TW'(TREM_MAX) : I_PWDATA[TW-1:0];
      end else if (A_RDLY == I_PADDR) begin
        n.rdly = I_PWDATA[TW-1:0];
      end else if (A_RSEL == I_PADDR) begin
        n.rsel = (I_PWDATA < 32'(REC_N)) ? I_PWDATA[REC_IW-1:0] : '0;
      end
    end
  end

  // State register, cleared to normal on reset
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.thr <= THR_RST;
      s.hlim <= HLIM_RST;
      s.dly <= DLY_RST;
      s.rdly <= RDLY_RST;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign O_START = s.start;
  assign O_TRIP = s.trip;
  assign O_BLOCKED = s.blocked;
  assign O_EVT = s.evt;
  assign O_EVT_STAMP = s.evt_stamp;
  assign O_HMI_EVT = s.hmi;
  assign O_PREADY = s.pready;
  assign O_PRDATA = s.prdata;
  assign O_PSLVERR = s.pslverr;

  // Checks on stage behaviour
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);

  sequence s_norm_tick;
    s.tick && s.cond == C_NORMAL && !s.ctrl[F_TEST];
  endsequence
  sequence s_start_tick;
    s.tick && s.cond == C_START && !s.ctrl[F_TEST];
  endsequence
  sequence s_apb_setup;
    I_PSEL && !I_PENABLE;
  endsequence

  chk_pickup_start: assert property (
    (s_norm_tick ##0 (meas > s.thr && !blk)) |=> O_START && !O_BLOCKED)
    else $error("pick-up without block did not start");
  chk_release_hold: assert property (
    (s_start_tick ##0 (above_rel && !blk)) |=> O_START)
    else $error("start dropped above release level");
  chk_block_instead: assert property (
    (s_norm_tick ##0 (meas > s.thr && blk)) |=> O_BLOCKED && !O_START)
    else $error("blocked pick-up did not give blocked");
  chk_block_drops: assert property (
    (s_start_tick ##0 blk) |=> !O_START && s.cond == C_NORMAL
      && s.elapsed == $past(s.elapsed))
    else $error("block during start not handled as drop-out");
  chk_out_exclusive: assert property (
    O_BLOCKED |-> !O_START && !O_TRIP)
    else $error("blocked together with start or trip");
  chk_force_trip: assert property (
    (s.ctrl[F_TEST] && s.ctrl[F_FORCE +: 2] == 2'h2) |=> O_TRIP && O_START)
    else $error("forced trip not shown");
  chk_comm_gate: assert property (
    (I_COMM_WR && s.ctrl[F_COMM +: 2] != COMM_ALLOW && !apb_wr) |=> $stable(s.thr))
    else $error("threshold changed while bus setting disabled");
  chk_start_event: assert property (
    $rose(O_START) |-> O_EVT[5] && O_EVT_STAMP == $past(s.stamp))
    else $error("start edge without stamped event");
  chk_instant_mode: assert property (
    (s_norm_tick ##0 (meas > s.thr && !blk && s.dly == '0))
      |=> O_TRIP && O_EVT[5] && O_EVT[3])
    else $error("instant trip events not simultaneous");
  chk_block_hmi: assert property (
    $rose(O_BLOCKED) |-> O_HMI_EVT && O_EVT[1])
    else $error("block without display event");
  chk_apb_answer: assert property (
    s_apb_setup |=> O_PREADY)
    else $error("apb access phase not answered");
  chk_ring_ptr: assert property (
    s.wptr < 4'(REC_N) && s.rsel < 4'(REC_N))
    else $error("record pointer out of range");
endmodule

// ### rcp_pkg.sv
// Purpose: Shared constants for the residual current stage
// Assumes: 200 MHz core clock, 5 ms processing cycle
// Notes: Times kept in their own unit, counts derived
package rcp_pkg;
  // APB register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_THRESH = 8'h04;
  localparam logic [7:0] A_HLIM = 8'h08;
  localparam logic [7:0] A_DLY = 8'h0c;
  localparam logic [7:0] A_RDLY = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;
  localparam logic [7:0] A_TREM = 8'h18;
  localparam logic [7:0] A_TEXP = 8'h1c;
  localparam logic [7:0] A_RATIO = 8'h20;
  localparam logic [7:0] A_ANGLE = 8'h24;
  localparam logic [7:0] A_RSEL = 8'h28;
  localparam logic [7:0] A_RSTAMP = 8'h2c;
  localparam logic [7:0] A_RINFO = 8'h30;
  // Control field positions
  localparam int F_COMM = 0;
  localparam int F_FORCE = 2;
  localparam int F_MAG = 4;
  localparam int F_SRC = 6;
  localparam int F_HARM = 8;
  localparam int F_TEST = 9;
  localparam int F_SOFTBLK = 10;
  localparam int F_IDMT = 11;
  localparam int CTRL_W = 12;
  localparam logic [11:0] CTRL_RST = 12'h051;
  // Setting codes
  localparam logic [1:0] COMM_ALLOW = 2'h2;
  localparam logic [1:0] MAG_TRMS = 2'h2;
  localparam logic [1:0] MAG_PP = 2'h3;
  localparam logic [1:0] SRC_SENS = 2'h2;
  localparam logic [1:0] SRC_CALC = 2'h3;
  // Widths
  localparam int MW = 20;
  localparam int TW = 19;
  localparam int RW = 17;
  localparam int AW = 17;
  localparam int REC_IW = 4;
  // Reset values and limits
  localparam logic [MW-1:0] THR_RST = 20'h02ee0;
  localparam logic [15:0] HLIM_RST = 16'h0001;
  localparam logic [TW-1:0] DLY_RST = 19'h00014;
  localparam logic [TW-1:0] RDLY_RST = 19'h00008;
  localparam logic [RW-1:0] RATIO_MAX = 17'h1e848;
  localparam int HYST_PCT = 97;
  localparam int PCT = 100;
  // Timing
  localparam int CLK_MHZ = 200;
  localparam int CYCLE_US = 5000;
  localparam int STAMP_US = 1000;
  localparam int CYCLE_CLKS = CYCLE_US * CLK_MHZ;
  localparam int STAMP_CLKS = STAMP_US * CLK_MHZ;
  localparam int TREM_MAX_S = 1800;
  localparam int TREM_MAX = TREM_MAX_S * 1000000 / CYCLE_US;
  localparam int REC_N = 12;
  // Stage condition codes
  typedef enum logic [1:0] {
    C_NORMAL = 2'b00,
    C_START = 2'b01,
    C_TRIP = 2'b10,
    C_BLOCKED = 2'b11
  } rcp_cond_t;
  // One event record
  typedef struct packed {
    logic [31:0] stamp;
    logic [1:0] ev;
    logic [2:0] ftype;
    logic [MW-1:0] cur;
  } rcp_rec_t;
endpackage

// ### rcp_meas_model.sv
// Purpose: Measurement and blocking source model for the stage
// Assumes: Runs on the stage clock
// Notes: Channels not carrying the level show a moving low pattern
`timescale 1ns/1ps
module rcp_meas_model
  import rcp_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Requested stimulus
  input wire logic [rcp_pkg::MW-1:0] i_level,
  input wire logic [2:0] i_chan,
  input wire logic i_blk,
  // Values toward the stage
  output logic [rcp_pkg::MW-1:0] o_mag [7],
  output logic o_block
);
  logic [2:0] wig;

  // One channel carries the level, the rest a small changing value
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wig <= 3'h0;
      o_block <= 1'b0;
      for (int k = 0; k < 7; k++) begin
        o_mag[k] <= '0;
      end
    end else begin
      wig <= wig + 3'h1;
      o_block <= i_blk; // Follows the requested block one clock later
      for (int k = 0; k < 7; k++) begin
        o_mag[k] <= (k == int'(i_chan)) ? i_level : MW'(wig);
      end
    end
  end
endmodule

// ### rcp_stage_tb.sv
// Purpose: Self-checking bench for the residual current stage
// Assumes: Short processing cycle of 20 clocks
// Notes: Settings reached over APB
`timescale 1ns/1ps
module rcp_stage_tb;
  import rcp_pkg::*;
  localparam int CYC = 20;
  localparam int MS = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [MW-1:0] mag [7];
  logic [MW-1:0] level = '0;
  logic [2:0] chan = 3'h0;
  logic blk = 1'b0;
  logic blk_q;
  logic [15:0] harm = 16'h0;
  logic comm_wr = 1'b0;
  logic [MW-1:0] comm_thr = '0;
  logic st, tr, bl, hmi;
  logic [5:0] evt;
  logic [31:0] evt_st;
  logic [5:0] evt_or = 6'h00;
  logic [31:0] st_on = 32'h0;
  logic [31:0] st_tr = 32'h0;
  logic volt_ok = 1'b1;
  logic hmi_seen = 1'b0;
  logic start_seen = 1'b0;
  logic [31:0] rd;
  logic er;
  int n_fail = 0;
  int n_checks = 0;

  always #2.5 clk = ~clk;

  rcp_stage #(.CYCLE_CLKS(CYC), .STAMP_CLKS(MS)) i_dut (
    .I_CORE_CLK(clk), .I_RESET_N(rst_n),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(pready),
    .O_PRDATA(prdata), .O_PSLVERR(pslverr),
    .I_COARSE_RMS(mag[0]), .I_COARSE_TRMS(mag[1]), .I_COARSE_PP(mag[2]),
    .I_SENS_RMS(mag[3]), .I_SENS_TRMS(mag[4]), .I_SENS_PP(mag[5]),
    .I_CALC(mag[6]), .I_HARM2_RATIO(harm), .I_BLOCK(blk_q),
    .I_FAULT_TYPE(3'h4), .I_RES_ANGLE(16'h1000), .I_VREF_ANGLE(16'h0800),
    .I_IREF_ANGLE(16'h0400), .I_VOLT_OK(volt_ok),
    .I_COMM_WR(comm_wr), .I_COMM_THRESH(comm_thr),
    .O_START(st), .O_TRIP(tr), .O_BLOCKED(bl),
    .O_EVT(evt), .O_EVT_STAMP(evt_st), .O_HMI_EVT(hmi)
  );

  rcp_meas_model i_meas (
    .i_core_clk(clk), .i_reset_n(rst_n), .i_level(level),
    .i_chan(chan), .i_blk(blk), .o_mag(mag), .o_block(blk_q)
  );

  // Sticky flags for short pulses
  always @(posedge clk) begin
    if (hmi === 1'b1) hmi_seen <= 1'b1;
    if (st === 1'b1) start_seen <= 1'b1;
    if (evt != 6'h00) evt_or <= evt_or | evt;
    if (evt[5] === 1'b1) st_on <= evt_st;
    if (evt[3] === 1'b1) st_tr <= evt_st;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  // One APB transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic stim(input logic [MW-1:0] l, input logic [2:0] c, input logic b);
    @(posedge clk);
    level <= l;
    chan <= c;
    blk <= b;
  endtask

  task automatic ticks(input int n);
    repeat (n * CYC) @(posedge clk);
  endtask

  // Waits for start, trip or blocked to reach a level
  task automatic wait_out(input int sel, input logic v, input int lim);
    int k;
    logic [2:0] o;
    k = 0;
    o = {bl, tr, st};
    while (o[sel] !== v && k < lim) begin
      @(posedge clk);
      k++;
      o = {bl, tr, st};
    end
  endtask

  task automatic t_regs();
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, 32'(CTRL_RST), "ctrl reset");
    apb(1'b1, 8'hfc, 32'h1);
    chk(32'(er), 32'h1, "unmapped error");
    apb(1'b0, A_THRESH, 32'h0);
    chk(rd, 32'(THR_RST), "threshold reset");
    apb(1'b1, A_THRESH, 32'd1000);
    apb(1'b1, A_DLY, 32'd3);
    apb(1'b1, A_RDLY, 32'd1);
    $display("test regs done");
  endtask

  task automatic t_pick();
    int n;
    n = 0;
    stim(20'd1000, 3'h0, 1'b0);
    ticks(3);
    chk(32'(st), 32'h0, "equal level started");
    evt_or = 6'h00;
    stim(20'd1001, 3'h0, 1'b0);
    wait_out(0, 1'b1, 3 * CYC);
    chk(32'(st), 32'h1, "no start");
    while (tr !== 1'b1 && n < 10 * CYC) begin
      @(posedge clk);
      n++;
    end
    chk(32'(n), 32'(2 * CYC), "trip delay");
    apb(1'b0, A_STATUS, 32'h0);
    chk(32'(rd[1:0]), 32'(C_TRIP), "status trip");
    chk(32'(rd[4:2]), 32'h4, "fault type");
    chk(32'(evt_or), 32'h28, "start and trip on events");
    chk(st_tr - st_on, 32'(2 * CYC / MS), "trip stamp distance");
    apb(1'b0, A_RATIO, 32'h0);
    chk(rd, 32'd100, "current ratio");
    apb(1'b0, A_ANGLE, 32'h0);
    chk(rd, 32'h800, "angle to voltage");
    volt_ok <= 1'b0;
    stim(20'd970, 3'h0, 1'b0);
    ticks(5);
    chk(32'(tr), 32'h1, "released above 97 percent");
    apb(1'b0, A_ANGLE, 32'h0);
    chk(rd, 32'hc00, "angle to current");
    stim(20'd969, 3'h0, 1'b0);
    wait_out(1, 1'b0, 5 * CYC);
    chk(32'(tr), 32'h0, "no release below 97 percent");
    // Instant mode, then the third record
    apb(1'b1, A_DLY, 32'h0);
    evt_or = 6'h00;
    stim(20'd1001, 3'h0, 1'b0);
    wait_out(1, 1'b1, 3 * CYC);
    apb(1'b1, A_RSEL, 32'h2);
    chk(32'(evt_or), 32'h28, "instant events");
    chk(st_tr, st_on, "instant stamps");
    apb(1'b0, A_RINFO, 32'h0);
    chk(rd, {7'h00, 2'h2, 3'h4, 20'd1001}, "record info");
    apb(1'b0, A_RSTAMP, 32'h0);
    chk(rd, st_tr, "record stamp");
    stim(20'd0, 3'h0, 1'b0);
    wait_out(1, 1'b0, 3 * CYC);
    // Inverse mode at twice the threshold halves the delay of 3
    apb(1'b1, A_DLY, 32'd3);
    apb(1'b1, A_CTRL, 32'(CTRL_RST) | 32'h800);
    stim(20'd2002, 3'h0, 1'b0);
    wait_out(1, 1'b1, 3 * CYC);
    apb(1'b0, A_TEXP, 32'h0);
    chk(rd, 32'd1, "inverse delay");
    apb(1'b1, A_CTRL, 32'(CTRL_RST));
    stim(20'd0, 3'h0, 1'b0);
    wait_out(1, 1'b0, 3 * CYC);
    $display("test pick done");
  endtask

  task automatic t_block();
    for (int b = 0; b < 3; b++) begin
      if (b > 0) begin
        apb(1'b1, A_CTRL, 32'(CTRL_RST) | ((b == 1) ? 32'h100 : 32'h600));
        harm <= (b == 1) ? 16'd200 : 16'h0;
      end
      stim(20'd0, 3'h0, b == 0);
      ticks(2);
      hmi_seen = 1'b0;
      start_seen = 1'b0;
      stim(20'd1001, 3'h0, b == 0);
      wait_out(2, 1'b1, 3 * CYC);
      chk(32'(bl), 32'h1, "no blocked");
      ticks(3);
      chk(32'(start_seen), 32'h0, "start under block");
      chk(32'(hmi_seen), 32'h1, "no display event");
      apb(1'b0, A_STATUS, 32'h0);
      chk(32'(rd[1:0]), 32'(C_BLOCKED), "status blocked");
      harm <= 16'h0;
      stim(20'd0, 3'h0, 1'b0);
      wait_out(2, 1'b0, 3 * CYC);
    end
    apb(1'b1, A_CTRL, 32'(CTRL_RST));
    stim(20'd1001, 3'h0, 1'b0);
    wait_out(0, 1'b1, 3 * CYC);
    stim(20'd1001, 3'h0, 1'b1);
    wait_out(0, 1'b0, 3 * CYC);
    chk(32'(st), 32'h0, "start kept under block");
    stim(20'd0, 3'h0, 1'b0);
    ticks(4);
    $display("test block done");
  endtask

  task automatic t_sel();
    int ch;
    for (int s = 1; s <= 3; s++) begin
      for (int m = 1; m <= 3; m++) begin
        ch = (s == 3) ? 6 : (s - 1) * 3 + m - 1;
        apb(1'b1, A_CTRL, 32'h1 | 32'(m << 4) | 32'(s << 6));
        stim(20'd1001, 3'((ch + 1) % 7), 1'b0);
        ticks(3);
        chk(32'(st), 32'h0, "wrong channel used");
        stim(20'd1001, 3'(ch), 1'b0);
        wait_out(0, 1'b1, 3 * CYC);
        chk(32'(st), 32'h1, "channel not used");
        stim(20'd0, 3'h0, 1'b0);
        wait_out(0, 1'b0, 6 * CYC);
      end
    end
    $display("test select done");
  endtask

  task automatic t_force();
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, A_CTRL, 32'h251 | 32'(f << 2));
      repeat (3) @(posedge clk);
      chk(32'({bl, tr, st}), (f == 2) ? 32'h3 : (f == 0) ? 32'h0 : 32'(1 << (f - 1)),
          "forced");
    end
    apb(1'b1, A_CTRL, 32'h059);
    repeat (3) @(posedge clk);
    chk(32'(tr), 32'h0, "forced without test");
    $display("test force done");
  endtask

  task automatic t_comm();
    for (int c = 1; c <= 2; c++) begin
      apb(1'b1, A_CTRL, 32'h050 | 32'(c));
      @(posedge clk);
      comm_wr <= 1'b1;
      comm_thr <= 20'd500;
      @(posedge clk);
      comm_wr <= 1'b0;
      apb(1'b0, A_THRESH, 32'h0);
      chk(rd, (c == 2) ? 32'd500 : 32'd1000, "bus threshold");
    end
    $display("test comm done");
  endtask

  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_pick();
    t_block();
    t_sel();
    t_force();
    t_comm();
    final_report();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
endmodule
